/* File: logic/tcc_regs.vh */
// register map, field positions and timing constants of the capture/compare timer
// Function
// - counter steps once every four bus clocks; prescale fixed, not software settable
// - counter advances on its own; reads never disturb the count
// - high-byte read freezes low byte in buffer; next low read returns it
// - mirror counter location reads same value, never helps clear overflow flag
// - reset presets counter to fffc; counting waits for start-up delay; read-only
// - wrap from ffff to 0000 sets overflow flag; interrupt if enabled
// - compare match sets channel flag, drives level to pin; shared enable
// - compare registers fully read/write, untouched by hardware and reset
// - high-byte compare write suspends compare until low byte written
// - level goes to pin on match whatever the flag; bytes written independently
// - second compare channel identical, own registers, flag, level and force
// - force bit write copies level to pin at once, with new level
// - forced compare changes only the pin, never flag or interrupt
// - selected capture edge latches counter; capture register survives reset
// - captured value is counter before the transition plus one
// - capture happens even while capture flag still set
// - capture high-byte read blocks captures until low byte read
// - second capture falls only; one shared capture interrupt enable
// - control bits 7..0 fixed; reset clears all but edge select
// - edge select one picks rising, zero falling; levels give pin value
// - status read-only: flags in bits 7..3, low bits read zero
// - flag clears after status access while set, then function low-byte access
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

`define TCC_ADDR_CTRL      8'h12
`define TCC_ADDR_STAT      8'h13
`define TCC_ADDR_CAP1_HI   8'h14
`define TCC_ADDR_CAP1_LO   8'h15
`define TCC_ADDR_CMP1_HI   8'h16
`define TCC_ADDR_CMP1_LO   8'h17
`define TCC_ADDR_CNT_HI    8'h18
`define TCC_ADDR_CNT_LO    8'h19
`define TCC_ADDR_ALT_HI    8'h1a
`define TCC_ADDR_ALT_LO    8'h1b
`define TCC_ADDR_CAP2_HI   8'h1c
`define TCC_ADDR_CAP2_LO   8'h1d
`define TCC_ADDR_CMP2_HI   8'h1e
`define TCC_ADDR_CMP2_LO   8'h1f

// control bit positions
`define TCC_CTL_CAP_IE     7
`define TCC_CTL_CMP_IE     6
`define TCC_CTL_OVF_IE     5
`define TCC_CTL_FORCE_B    4
`define TCC_CTL_FORCE_A    3
`define TCC_CTL_LEVEL_B    2
`define TCC_CTL_EDGE       1
`define TCC_CTL_LEVEL_A    0

// flag vector index; status bit is index plus three
`define TCC_FLG_CAP_A      4
`define TCC_FLG_CMP_A      3
`define TCC_FLG_OVF        2
`define TCC_FLG_CAP_B      1
`define TCC_FLG_CMP_B      0
`define TCC_STAT_PAD       3'h0

`define TCC_CNT_RESET      16'hfffc
`define TCC_CNT_MAX        16'hffff
`define TCC_CNT_ONE        16'h0001
`define TCC_PRESC_LAST     2'h3
`define TCC_STARTUP_CYC    16'h0010
`define TCC_BYTE_ZERO      8'h00

`endif

/* File: logic/tcc_sync.v */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tcc_sync (
    input  wire ref_clk,
    input  wire rstn,
    input  wire clk_en,
    input  wire pin,
    output reg  level_q,
    output reg  rise_q,
    output reg  fall_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg v1_q;
    reg v2_q;
    reg v3_q;

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            v1_q    <= 1'b0;
            v2_q    <= 1'b0;
            v3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_q   <= pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            v1_q   <= 1'b1;
            v2_q   <= v1_q;
            v3_q   <= v2_q;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            // adopt the pin's level silently once the stages hold real samples,
            // so an idle-high pin gives no false edge after reset
            if (!v3_q)
                level_q <= s2_q;
            // only a level seen on two stages counts, so a one-cycle glitch is dropped
            else if (s2_q == s3_q && s3_q != level_q)
            begin
                level_q <= s3_q;
                rise_q  <= s3_q;
                fall_q  <= ~s3_q;
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/tcc_cmp.v */
// one output compare channel: value bytes, write interlock, match and pin latch
`timescale 1ns/1ps
`default_nettype none
module tcc_cmp (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        clk_en,
    input  wire        wr_hi,
    input  wire        wr_lo,
    input  wire [7:0]  wdata,
    input  wire [15:0] count,
    input  wire        count_new,
    input  wire        level,
    input  wire        force_en,
    input  wire        force_level,
    output reg  [15:0] value_q,
    output reg         match_q,
    output reg         pin_q
);
    reg inhibit_q;

    // no reset here: the value survives reset and is only changed by software
    always @(posedge ref_clk)
    begin
        if (clk_en && wr_hi)
            value_q[15:8] <= wdata;
        if (clk_en && wr_lo)
            value_q[7:0] <= wdata;
    end

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            inhibit_q <= 1'b0;
            match_q   <= 1'b0;
            pin_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_lo)
                inhibit_q <= 1'b0;
            else if (wr_hi)
                inhibit_q <= 1'b1;
            match_q <= 1'b0;
            if (count_new && !inhibit_q && count == value_q)
            begin
                match_q <= 1'b1;
                pin_q   <= level;
            end
            // force overrides a match in the same cycle; flag path untouched
            if (force_en)
                pin_q <= force_level;
        end
    end
endmodule
`default_nettype wire

/* File: logic/tcc_timer.v */
// 16-bit timer with two input captures, two output compares and overflow
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_timer #(
    parameter [15:0] STARTUP_CYCLES = `TCC_STARTUP_CYC
) (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire       clk_en,
    input  wire [7:0] bus_addr,
    input  wire       bus_rd,
    input  wire       bus_wr,
    input  wire [7:0] bus_wdata,
    output reg  [7:0] bus_rdata_q,
    input  wire       capture_pin_a,
    input  wire       capture_pin_b,
    output wire       compare_pin_a,
    output wire       compare_pin_b,
    output reg        timer_irq_q
);
    // control register fields
    reg         capture_irq_enable_q;
    reg         compare_irq_enable_q;
    reg         overflow_irq_enable_q;
    reg         out_level_a_q;
    reg         out_level_b_q;
    reg         capture_edge_select_q;

    // counter and prescaler
    reg  [1:0]  presc_q;
    reg  [15:0] start_cnt_q;
    reg         running_q;
    reg  [15:0] count_q;
    reg         count_new_q;
    reg  [15:0] count_d1_q;
    reg  [15:0] count_d2_q;
    reg  [7:0]  cnt_buf_q;
    reg         cnt_buf_valid_q;

    // flags, clear arming, captures
    reg  [4:0]  flag_q;
    reg  [4:0]  arm_q;
    reg  [15:0] cap_q [0:1];
    reg  [7:0]  cap_buf_q [0:1];
    reg  [1:0]  cap_inh_q;

    wire        rd;
    wire        wr;
    wire        acc;
    wire        tick;
    wire        wrap;
    wire [4:0]  flag_set;
    wire [4:0]  flag_low_acc;
    wire [1:0]  cap_edge;
    wire [1:0]  cap_rise;
    wire [1:0]  cap_fall;
    wire [1:0]  cap_hi_rd;
    wire [1:0]  cap_lo_rd;
    wire [1:0]  cmp_match;
    wire [15:0] cmp_val_a;
    wire [15:0] cmp_val_b;
    wire        ctl_wr;
    wire [7:0]  ctl_rd;
    wire [7:0]  stat_rd;
    wire        cnt_hi_rd;
    wire        cnt_lo_rd;

    assign rd   = bus_rd & clk_en;
    assign wr   = bus_wr & clk_en;
    assign acc  = rd | wr;
    assign tick = running_q & (presc_q == `TCC_PRESC_LAST);
    assign wrap = tick & (count_q == `TCC_CNT_MAX);

    assign ctl_wr = wr & (bus_addr == `TCC_ADDR_CTRL);

    // prescaler has no software access, so its ratio can never change
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            presc_q     <= 2'h0;
            start_cnt_q <= 16'h0000;
            running_q   <= 1'b0;
            count_q     <= `TCC_CNT_RESET;
            count_new_q <= 1'b0;
            count_d1_q  <= `TCC_CNT_RESET;
            count_d2_q  <= `TCC_CNT_RESET;
        end
        else if (clk_en)
        begin
            if (!running_q)
            begin
                // hold off until the start-up delay has passed
                start_cnt_q <= start_cnt_q + `TCC_CNT_ONE;
                if (start_cnt_q == STARTUP_CYCLES)
                    running_q <= 1'b1;
            end
            else
                presc_q <= presc_q + 2'h1;
            count_new_q <= tick;
            if (tick)
                count_q <= count_q + `TCC_CNT_ONE;
            // delayed copies line the count up with the pin synchroniser latency
            count_d1_q <= count_q;
            count_d2_q <= count_d1_q;
        end
    end

    // capture inputs: synchroniser per channel, then edge choice for channel a; channel b is falling only
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_cap
            tcc_sync u_sync (
                .ref_clk (ref_clk),
                .rstn    (rstn),
                .clk_en  (clk_en),
                .pin     (gi == 0 ? capture_pin_a : capture_pin_b),
                .level_q (),
                .rise_q  (cap_rise[gi]),
                .fall_q  (cap_fall[gi])
            );

            // no reset: a captured value survives reset
            always @(posedge ref_clk)
            begin
                if (clk_en && cap_edge[gi] && !cap_inh_q[gi])
                    cap_q[gi] <= count_d2_q + `TCC_CNT_ONE;
            end

            always @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    cap_inh_q[gi] <= 1'b0;
                else if (cap_lo_rd[gi])
                    cap_inh_q[gi] <= 1'b0;
                else if (cap_hi_rd[gi])
                    cap_inh_q[gi] <= 1'b1;
            end

            always @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    cap_buf_q[gi] <= `TCC_BYTE_ZERO;
                else if (clk_en)
                    cap_buf_q[gi] <= cap_q[gi][7:0];
            end
        end
    endgenerate

    assign cap_edge[0] = capture_edge_select_q ? cap_rise[0] : cap_fall[0];
    assign cap_edge[1] = cap_fall[1];

    assign cap_hi_rd[0] = rd & (bus_addr == `TCC_ADDR_CAP1_HI);
    assign cap_lo_rd[0] = rd & (bus_addr == `TCC_ADDR_CAP1_LO);
    assign cap_hi_rd[1] = rd & (bus_addr == `TCC_ADDR_CAP2_HI);
    assign cap_lo_rd[1] = rd & (bus_addr == `TCC_ADDR_CAP2_LO);

    // output compare channels
    tcc_cmp u_cmp_a (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .clk_en      (clk_en),
        .wr_hi       (wr & (bus_addr == `TCC_ADDR_CMP1_HI)),
        .wr_lo       (wr & (bus_addr == `TCC_ADDR_CMP1_LO)),
        .wdata       (bus_wdata),
        .count       (count_q),
        .count_new   (count_new_q),
        .level       (out_level_a_q),
        .force_en    (ctl_wr & bus_wdata[`TCC_CTL_FORCE_A]),
        .force_level (bus_wdata[`TCC_CTL_LEVEL_A]),
        .value_q     (cmp_val_a),
        .match_q     (cmp_match[0]),
        .pin_q       (compare_pin_a)
    );

    tcc_cmp u_cmp_b (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .clk_en      (clk_en),
        .wr_hi       (wr & (bus_addr == `TCC_ADDR_CMP2_HI)),
        .wr_lo       (wr & (bus_addr == `TCC_ADDR_CMP2_LO)),
        .wdata       (bus_wdata),
        .count       (count_q),
        .count_new   (count_new_q),
        .level       (out_level_b_q),
        .force_en    (ctl_wr & bus_wdata[`TCC_CTL_FORCE_B]),
        .force_level (bus_wdata[`TCC_CTL_LEVEL_B]),
        .value_q     (cmp_val_b),
        .match_q     (cmp_match[1]),
        .pin_q       (compare_pin_b)
    );

    // control register; edge select kept out of reset on purpose
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            capture_irq_enable_q  <= 1'b0;
            compare_irq_enable_q  <= 1'b0;
            overflow_irq_enable_q <= 1'b0;
            out_level_a_q         <= 1'b0;
            out_level_b_q         <= 1'b0;
        end
        else if (ctl_wr)
        begin
            capture_irq_enable_q  <= bus_wdata[`TCC_CTL_CAP_IE];
            compare_irq_enable_q  <= bus_wdata[`TCC_CTL_CMP_IE];
            overflow_irq_enable_q <= bus_wdata[`TCC_CTL_OVF_IE];
            out_level_a_q         <= bus_wdata[`TCC_CTL_LEVEL_A];
            out_level_b_q         <= bus_wdata[`TCC_CTL_LEVEL_B];
        end
    end

    always @(posedge ref_clk)
    begin
        if (ctl_wr)
            capture_edge_select_q <= bus_wdata[`TCC_CTL_EDGE];
    end

    // flag events and their low-byte clear accesses
    assign flag_set[`TCC_FLG_CAP_A] = clk_en & cap_edge[0] & ~cap_inh_q[0];
    assign flag_set[`TCC_FLG_CAP_B] = clk_en & cap_edge[1] & ~cap_inh_q[1];
    assign flag_set[`TCC_FLG_CMP_A] = clk_en & cmp_match[0];
    assign flag_set[`TCC_FLG_CMP_B] = clk_en & cmp_match[1];
    assign flag_set[`TCC_FLG_OVF]   = clk_en & wrap;

    assign flag_low_acc[`TCC_FLG_CAP_A] = acc & (bus_addr == `TCC_ADDR_CAP1_LO);
    assign flag_low_acc[`TCC_FLG_CAP_B] = acc & (bus_addr == `TCC_ADDR_CAP2_LO);
    assign flag_low_acc[`TCC_FLG_CMP_A] = acc & (bus_addr == `TCC_ADDR_CMP1_LO);
    assign flag_low_acc[`TCC_FLG_CMP_B] = acc & (bus_addr == `TCC_ADDR_CMP2_LO);
    // the mirror low byte is left out so casual reads never lose an overflow
    assign flag_low_acc[`TCC_FLG_OVF]   = acc & (bus_addr == `TCC_ADDR_CNT_LO);

    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_flag
            always @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    flag_q[gi] <= 1'b0;
                    arm_q[gi]  <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (acc && bus_addr == `TCC_ADDR_STAT && flag_q[gi])
                        arm_q[gi] <= 1'b1;
                    else if (flag_low_acc[gi])
                        arm_q[gi] <= 1'b0;
                    // a new event in the clearing cycle keeps the flag set
                    if (flag_set[gi])
                        flag_q[gi] <= 1'b1;
                    else if (flag_low_acc[gi] && arm_q[gi])
                        flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // counter byte-order buffer shared by both counter locations
    assign cnt_hi_rd = rd & ((bus_addr == `TCC_ADDR_CNT_HI) | (bus_addr == `TCC_ADDR_ALT_HI));
    assign cnt_lo_rd = rd & ((bus_addr == `TCC_ADDR_CNT_LO) | (bus_addr == `TCC_ADDR_ALT_LO));

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_buf_q       <= `TCC_BYTE_ZERO;
            cnt_buf_valid_q <= 1'b0;
        end
        else if (cnt_lo_rd)
            cnt_buf_valid_q <= 1'b0;
        else if (cnt_hi_rd && !cnt_buf_valid_q)
        begin
            cnt_buf_q       <= count_q[7:0];
            cnt_buf_valid_q <= 1'b1;
        end
    end

    assign ctl_rd = {capture_irq_enable_q, compare_irq_enable_q, overflow_irq_enable_q,
                     2'b00, out_level_b_q, capture_edge_select_q, out_level_a_q};
    assign stat_rd = {flag_q, `TCC_STAT_PAD};

    // read data is registered; reads change no timer state except the counter byte buffer, the interlocks and the flag arm/clear logic
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            bus_rdata_q <= `TCC_BYTE_ZERO;
        else if (rd)
        begin
            case (bus_addr)
                `TCC_ADDR_CTRL:    bus_rdata_q <= ctl_rd;
                `TCC_ADDR_STAT:    bus_rdata_q <= stat_rd;
                `TCC_ADDR_CAP1_HI: bus_rdata_q <= cap_q[0][15:8];
                `TCC_ADDR_CAP1_LO: bus_rdata_q <= cap_q[0][7:0];
                `TCC_ADDR_CMP1_HI: bus_rdata_q <= cmp_val_a[15:8];
                `TCC_ADDR_CMP1_LO: bus_rdata_q <= cmp_val_a[7:0];
                `TCC_ADDR_CNT_HI,
                `TCC_ADDR_ALT_HI:  bus_rdata_q <= count_q[15:8];
                `TCC_ADDR_CNT_LO,
                `TCC_ADDR_ALT_LO:  bus_rdata_q <= cnt_buf_valid_q ? cnt_buf_q
                                                                  : count_q[7:0];
                `TCC_ADDR_CAP2_HI: bus_rdata_q <= cap_q[1][15:8];
                `TCC_ADDR_CAP2_LO: bus_rdata_q <= cap_q[1][7:0];
                `TCC_ADDR_CMP2_HI: bus_rdata_q <= cmp_val_b[15:8];
                `TCC_ADDR_CMP2_LO: bus_rdata_q <= cmp_val_b[7:0];
                default:           bus_rdata_q <= `TCC_BYTE_ZERO;
            endcase
        end
    end

    // single interrupt request, held while any enabled flag remains set
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            timer_irq_q <= 1'b0;
        else if (clk_en)
            timer_irq_q <= (capture_irq_enable_q & (flag_q[`TCC_FLG_CAP_A] | flag_q[`TCC_FLG_CAP_B]))
                         | (compare_irq_enable_q & (flag_q[`TCC_FLG_CMP_A] | flag_q[`TCC_FLG_CMP_B]))
                         | (overflow_irq_enable_q & flag_q[`TCC_FLG_OVF]);
    end
endmodule
`default_nettype wire

/* File: sim/tcc_timer_checker.sv */
// checker: bus and pin relations of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_checker (
    input wire       ref_clk,
    input wire       rstn,
    input wire       clk_en,
    input wire [7:0] bus_addr,
    input wire       bus_rd,
    input wire       bus_wr,
    input wire [7:0] bus_wdata,
    input wire [7:0] bus_rdata_q,
    input wire       compare_pin_a,
    input wire       compare_pin_b,
    input wire       timer_irq_q
);
    reg  [7:0] sh_q;
    reg  [7:0] sh1_q;
    reg  [7:0] sh2_q;
    wire       rd_go;
    wire       ctl_wr;
    assign rd_go  = clk_en && bus_rd;
    assign ctl_wr = clk_en && bus_wr && bus_addr == 8'h12;
    // shadow of control, delayed so the design's write latency never trips a check
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sh_q  <= 8'h00;
            sh1_q <= 8'h00;
            sh2_q <= 8'h00;
        end
        else
        begin
            sh_q  <= ctl_wr ? (bus_wdata & 8'he5) : sh_q;
            sh1_q <= sh_q;
            sh2_q <= sh1_q;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_unmapped_zero: assert property (rd_go && (bus_addr < 8'h12 || bus_addr > 8'h1f)
        |=> bus_rdata_q == 8'h00) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!rd_go |=> $stable(bus_rdata_q))
        else $error("read data moved without a read");
    chk_status_pad: assert property (rd_go && bus_addr == 8'h13
        |=> bus_rdata_q[2:0] == 3'h0) else $error("status low bits not zero");
    chk_ctrl_readback: assert property (rd_go && bus_addr == 8'h12
        && sh_q == sh1_q && sh1_q == sh2_q |=> (bus_rdata_q & 8'hfd) == sh_q)
        else $error("control readback wrong");
    chk_force_pin_a: assert property (ctl_wr && bus_wdata[3]
        |=> ##1 compare_pin_a == $past(bus_wdata[0], 2)) else $error("force a wrong");
    chk_force_pin_b: assert property (ctl_wr && bus_wdata[4]
        |=> ##1 compare_pin_b == $past(bus_wdata[2], 2)) else $error("force b wrong");
    chk_irq_masked: assert property (((sh_q | sh1_q | sh2_q) & 8'he0) == 8'h00
        |-> !timer_irq_q) else $error("irq with all enables off");
    chk_pins_reset: assert property ($rose(rstn) |-> !compare_pin_a && !compare_pin_b)
        else $error("compare pins not low after reset");
endmodule
bind tcc_timer tcc_timer_checker u_chk (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .clk_en        (clk_en),
    .bus_addr      (bus_addr),
    .bus_rd        (bus_rd),
    .bus_wr        (bus_wr),
    .bus_wdata     (bus_wdata),
    .bus_rdata_q   (bus_rdata_q),
    .compare_pin_a (compare_pin_a),
    .compare_pin_b (compare_pin_b),
    .timer_irq_q   (timer_irq_q)
);
`default_nettype wire

/* File: sim/tcc_far.sv */
// far-side model: drives the capture inputs; the compare outputs come in but are not used
`timescale 1ns/1ps
`default_nettype none
module tcc_far (
    input  wire logic ref_clk,
    input  wire logic compare_pin_a,
    input  wire logic compare_pin_b,
    output var  logic cap_a,
    output var  logic cap_b
);
    initial
    begin
        cap_a = 1'b1;
        cap_b = 1'b1;
    end
    // level held five edges: the synchroniser needs agreeing samples
    task automatic drive(input logic sel, input logic v);
        @(posedge ref_clk);
        #1;
        if (sel)
            cap_b = v;
        else
            cap_a = v;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// testbench: register-level tests of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  bus_addr = 8'h00;
    logic        bus_rd = 1'b0;
    logic        bus_wr = 1'b0;
    logic [7:0]  bus_wdata = 8'h00;
    wire  [7:0]  bus_rdata_q;
    wire         cap_a;
    wire         cap_b;
    wire         pin_a;
    wire         pin_b;
    wire         irq;
    int          err_total = 0;
    int          check_count = 0;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  h;
    logic [15:0] t;
    logic [15:0] u;
    always #5 ref_clk = ~ref_clk;
    tcc_timer #(.STARTUP_CYCLES(16'h0002)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1), .bus_addr(bus_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .bus_rdata_q(bus_rdata_q), .capture_pin_a(cap_a), .capture_pin_b(cap_b),
        .compare_pin_a(pin_a), .compare_pin_b(pin_b), .timer_irq_q(irq));
    tcc_far far (.ref_clk(ref_clk), .compare_pin_a(pin_a), .compare_pin_b(pin_b),
        .cap_a(cap_a), .cap_b(cap_b));
    task automatic summarize;
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask
    // one strobe cycle, then an idle edge so strobes never re-assert in one step
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        #1;
        bus_addr = a;
        bus_wdata = v;
        bus_rd = !w;
        bus_wr = w;
        @(posedge ref_clk);
        #1;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        d = bus_rdata_q;
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        bus(1'b0, a, 8'h00);
        chk(d & m, x);
    endtask
    task automatic reset_dut;
        rstn = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
    endtask
    initial
    begin
        #200000;
        err_total++;
        summarize;
    end
    initial
    begin
        reset_dut;
        rc(8'h18, 8'hff, 8'hff);
        rc(8'h19, 8'hfc, 8'hff);
        rc(8'h12, 8'h00, 8'hfd);
        repeat (30) @(posedge ref_clk);
        rc(8'h13, 8'h20, 8'h27);
        rd(8'h1b);
        rc(8'h13, 8'h20, 8'h20);
        rd(8'h19);
        rc(8'h13, 8'h00, 8'h20);
        rd(8'h1b);
        e = d;
        repeat (38) @(posedge ref_clk);
        rc(8'h1b, e + 8'h0a, 8'hff);
        rd(8'h18);
        repeat (36) @(posedge ref_clk);
        rd(8'h18);
        rd(8'h19);
        e = d;
        repeat (2) @(posedge ref_clk);
        rc(8'h1b, e + 8'h0b, 8'hff);
        rd(8'h18);
        h = d;
        rd(8'h19);
        t = {h, d} + 16'h0014;
        // low then high: channel b stays suspended past its match
        wr(8'h1f, t[7:0]);
        wr(8'h1e, t[15:8]);
        wr(8'h16, t[15:8]);
        wr(8'h17, t[7:0]);
        wr(8'h12, 8'h45);
        rc(8'h16, t[15:8], 8'hff);
        rc(8'h17, t[7:0], 8'hff);
        repeat (100) @(posedge ref_clk);
        chk({6'h00, pin_b, pin_a}, 8'h01);
        chk({7'h00, irq}, 8'h01);
        rc(8'h13, 8'h40, 8'h48);
        rd(8'h17);
        rc(8'h13, 8'h00, 8'h40);
        chk({7'h00, irq}, 8'h00);
        u = t + 16'h0014;
        wr(8'h1e, u[15:8]);
        wr(8'h1f, u[7:0]);
        repeat (100) @(posedge ref_clk);
        chk({6'h00, pin_b, pin_a}, 8'h03);
        rc(8'h13, 8'h08, 8'h48);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h12, (i == 0) ? 8'h18 : 8'h1d);
            repeat (2) @(posedge ref_clk);
            chk({6'h00, pin_b, pin_a}, (i == 0) ? 8'h00 : 8'h03);
            rc(8'h13, 8'h00, 8'h40);
        end
        rd(8'h1b);
        e = d;
        far.drive(1'b1, 1'b0);
        rd(8'h1c);
        h = d;
        rd(8'h1d);
        t = {h, d};
        chk({7'h00, (d - e - 8'h01) < 8'h02}, 8'h01);
        rd(8'h1c);
        far.drive(1'b1, 1'b1);
        far.drive(1'b1, 1'b0);
        rc(8'h1d, t[7:0], 8'hff);
        far.drive(1'b1, 1'b1);
        far.drive(1'b1, 1'b0);
        rc(8'h13, 8'h10, 8'h10);
        rd(8'h1c);
        h = d;
        rd(8'h1d);
        chk({7'h00, d != t[7:0]}, 8'h01);
        t = {h, d};
        for (int i = 0; i < 2; i++)
        begin
            far.drive(1'b0, i[0]);
            wr(8'h12, {6'h00, i[0], 1'b0});
            rd(8'h13);
            rd(8'h15);
            far.drive(1'b0, !i[0]);
            rc(8'h13, 8'h00, 8'h80);
            far.drive(1'b0, i[0]);
            rc(8'h13, 8'h80, 8'h80);
        end
        reset_dut;
        rc(8'h18, 8'hff, 8'hff);
        rc(8'h12, 8'h02, 8'hff);
        rc(8'h1c, t[15:8], 8'hff);
        rc(8'h1d, t[7:0], 8'hff);
        rc(8'h1e, u[15:8], 8'hff);
        chk({6'h00, pin_b, pin_a}, 8'h00);
        summarize;
    end
endmodule
`default_nettype wire
